// File: design/ssp_host.sv
`timescale 1ns/1ps
module ssp_host
  import ssp_pkg::*;
#(
  parameter int HALF_CYC     = SCLK_HALF_CYC,
  parameter int MOT_WAIT_CYC = MOT_RST_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset,
  ssp_if.host             link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic       cmd_burst,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [3:0] cmd_len,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            motion_ok
);

  localparam int TW = 12;
  localparam int MW = $clog2(MOT_WAIT_CYC + 1);
  localparam logic [TW-1:0] HALF_LD = TW'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC > 15)
    $error("ssp_host: half period below link limit or too long");
  if (SWW_CYC >= (1 << TW) || SRAD_CYC >= (1 << TW))
    $error("ssp_host: interval timer too narrow");
  if (MOT_WAIT_CYC < 1 || WAKEUP_CYC > MOT_WAIT_CYC && MOT_WAIT_CYC
      == MOT_RST_CYC)
    $error("ssp_host: motion wait shorter than wakeup");

  ////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [2:0] {
    SSPH_IDLE,
    SSPH_SETUP,
    SSPH_SHIFT,
    SSPH_WAIT_AD,
    SSPH_HOLD
  } ssph_state_t;

  typedef struct packed {
    ssph_state_t   state;
    logic [TW-1:0] tcnt;
    logic [TW-1:0] gap;
    logic [TW-1:0] half;
    logic [2:0]    bitn;
    logic          data_ph;
    logic          wr;
    logic          burst;
    logic [3:0]    left;
    logic [7:0]    wdata;
    logic [7:0]    sh;
    logic [7:0]    rx;
    logic          sclk;
    logic          ncs;
    logic          mosi;
    logic          miso_s1;
    logic          miso_s2;
    logic          rsp_valid;
    logic [7:0]    rsp_data;
    logic [MW-1:0] mot;
    logic          need_rst;
    logic          mot_arm;
    logic          mok;
  } ssph_reg_t;

  ssph_reg_t r_reg;
  ssph_reg_t r_next;

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.sclk = r_reg.sclk;
  assign link.ncs  = r_reg.ncs;
  assign link.mosi = r_reg.mosi;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data  = r_reg.rsp_data;
  assign motion_ok = r_reg.mok;
  // New command only once every spacing timer ran out
  assign cmd_ready = (r_reg.state == SSPH_IDLE) && (r_reg.gap == '0);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] rx_full;
    rx_full = '0;
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    // Miso comes from the far domain: two flops first
    r_next.miso_s1 = link.miso;
    r_next.miso_s2 = r_reg.miso_s1;
    // Down counters that stop at zero
    if (r_reg.gap != '0) begin
      r_next.gap = r_reg.gap - 1'b1;
    end
    if (r_reg.tcnt != '0) begin
      r_next.tcnt = r_reg.tcnt - 1'b1;
    end
    if (r_reg.mot != '0) begin
      r_next.mot = r_reg.mot - 1'b1;
    end

    case (r_reg.state)
      SSPH_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          r_next.ncs     = 1'b0;
          r_next.sh      = {cmd_write, cmd_addr};
          r_next.wr      = cmd_write;
          r_next.burst   = cmd_burst && !cmd_write;
          r_next.left    = cmd_len;
          r_next.wdata   = cmd_wdata;
          r_next.bitn    = '0;
          r_next.data_ph = 1'b0;
          r_next.tcnt    = TW'(NCS_SCLK_CYC);
          r_next.state   = SSPH_SETUP;
          // Restart delay armed now, started when the write commits
          r_next.mot_arm = cmd_write && (cmd_addr == ADDR_SOFT_RESET ||
                                         cmd_addr == ADDR_SHUTDOWN);
          if (cmd_write && cmd_addr == ADDR_SOFT_RESET) begin
            r_next.need_rst = 1'b0;
          end
          if (cmd_write && cmd_addr == ADDR_SHUTDOWN &&
              cmd_wdata[SHDN_BIT]) begin
            r_next.need_rst = 1'b1;
          end
        end
      end
      SSPH_SETUP: begin
        if (r_reg.tcnt == '0) begin
          r_next.half  = HALF_LD;
          r_next.state = SSPH_SHIFT;
        end
      end
      SSPH_SHIFT: begin
        if (r_reg.half != '0) begin
          r_next.half = r_reg.half - 1'b1;
        end else begin
          // Equal high and low phases of HALF_CYC cycles
          r_next.half = HALF_LD;
          if (r_reg.sclk) begin
            r_next.sclk = 1'b0;
            r_next.mosi = r_reg.sh[BYTE_BITS-1];
            r_next.sh   = {r_reg.sh[6:0], 1'b0};
          end else begin
            r_next.sclk = 1'b1;
            rx_full     = {r_reg.rx[6:0], r_reg.miso_s2};
            r_next.rx   = rx_full;
            r_next.bitn = r_reg.bitn + 1'b1;
            if (r_reg.bitn == 3'h7) begin
              if (!r_reg.data_ph) begin
                r_next.data_ph = 1'b1;
                if (r_reg.wr) begin
                  r_next.sh = r_reg.wdata;
                end else begin
                  r_next.tcnt  = TW'(SRAD_CYC);
                  r_next.state = SSPH_WAIT_AD;
                end
              end else if (r_reg.wr) begin
                r_next.tcnt  = TW'(WR_HOLD_CYC);
                // Counting from the take would trust motion too early
                if (r_reg.mot_arm) begin
                  r_next.mot = MW'(MOT_WAIT_CYC);
                end
                // Covers write-to-write and write-to-read alike
                r_next.gap   = TW'(SWW_CYC > SWR_CYC ? SWW_CYC
                                                     : SWR_CYC);
                r_next.state = SSPH_HOLD;
              end else begin
                r_next.rsp_valid = 1'b1;
                r_next.rsp_data  = rx_full;
                if (r_reg.burst && r_reg.left != '0) begin
                  r_next.left = r_reg.left - 1'b1;
                end else begin
                  r_next.tcnt  = TW'(RD_HOLD_CYC);
                  r_next.gap   = TW'(SRW_CYC);
                  r_next.state = SSPH_HOLD;
                end
              end
            end
          end
        end
      end
      SSPH_WAIT_AD: begin
        // Address-to-data delay counted before the first fall
        if (r_reg.tcnt == '0) begin
          r_next.half  = HALF_LD;
          r_next.state = SSPH_SHIFT;
        end
      end
      SSPH_HOLD: begin
        if (r_reg.tcnt == '0) begin
          // Every transaction framed; also ends a burst
          r_next.ncs   = 1'b1;
          r_next.state = SSPH_IDLE;
          if (r_next.gap < TW'(BEXIT_CYC)) begin
            r_next.gap = TW'(BEXIT_CYC);
          end
        end
      end
      default: begin
        r_next.state = SSPH_IDLE;
        r_next.ncs   = 1'b1;
        r_next.sclk  = 1'b1;
      end
    endcase
    r_next.mok = !r_next.need_rst && (r_next.mot == '0);
  end

  ////////////////////////////////////////////////////////////////////
  // Registers; need_rst starts set so the first reset is required
  always_ff @(posedge clock) begin
    if (reset) begin
      r_reg          <= '0;
      r_reg.state    <= SSPH_IDLE;
      r_reg.sclk     <= 1'b1;
      r_reg.ncs      <= 1'b1;
      r_reg.need_rst <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule // ssp_host

// File: design/ssp_pkg.sv
package ssp_pkg;

  // Host clock and derived rounding helpers
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_MAX_HZ   = 2_000_000;
  localparam int SCLK_HALF_CYC =
    (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);

  // Minimum link intervals, ns
  localparam int T_SWW_NS      = 120_000;
  localparam int T_SWR_NS      = 120_000;
  localparam int T_SRW_NS      = 20_000;
  localparam int T_SRAD_NS     = 100_000;
  localparam int T_BEXIT_NS    = 500;
  localparam int T_NCS_SCLK_NS = 120;
  localparam int T_WR_HOLD_NS  = 20_000;
  localparam int T_RD_HOLD_NS  = 120;
  // Mode latencies, ns; minimums round up, maximums down
  localparam int T_MOT_RST_NS  = 30_000_000;
  localparam int T_WAKEUP_NS   = 30_000_000;
  localparam int T_STDWN_NS    = 500_000_000;
  localparam int T_REST_EN_NS  = 1_000_000_000;
  localparam int T_REST_DIS_NS = 1_000_000_000;

  localparam int SWW_CYC   = (T_SWW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWR_CYC   = (T_SWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRW_CYC   = (T_SRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRAD_CYC  = (T_SRAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BEXIT_CYC = (T_BEXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NCS_SCLK_CYC =
    (T_NCS_SCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HOLD_CYC =
    (T_WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HOLD_CYC =
    (T_RD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MOT_RST_CYC =
    (T_MOT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKEUP_CYC =
    (T_WAKEUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STDWN_CYC    = T_STDWN_NS / CLK_PERIOD_NS;
  localparam int REST_EN_CYC  = T_REST_EN_NS / CLK_PERIOD_NS;
  localparam int REST_DIS_CYC = T_REST_DIS_NS / CLK_PERIOD_NS;

  // Link framing
  localparam int       WR_FLAG_BIT = 7;
  localparam int       ADDR_BITS   = 7;
  localparam int       BYTE_BITS   = 8;
  localparam bit [4:0] CNT_ADDR    = 5'h07;
  localparam bit [4:0] CNT_DATA0   = 5'h08;
  localparam bit [4:0] CNT_LAST    = 5'h0f;
  localparam bit [4:0] CNT_DONE    = 5'h10;

  // Device register addresses and fields
  localparam bit [6:0] ADDR_STATUS     = 7'h02;
  localparam bit [6:0] ADDR_SHUTDOWN   = 7'h03;
  localparam bit [6:0] ADDR_REST       = 7'h04;
  localparam bit [6:0] ADDR_SOFT_RESET = 7'h05;
  localparam bit [6:0] ADDR_BURST      = 7'h10;
  localparam int       STAT_VALID_BIT  = 0;
  localparam int       STAT_LOWPWR_BIT = 1;
  localparam int       SHDN_BIT        = 0;
  localparam int       REST_LSB        = 0;
  localparam int       REST_W          = 2;

endpackage

// File: design/ssp_if.sv
`timescale 1ns/1ps
// Four-wire link; miso resolved here from the device's enable
interface ssp_if;
  logic sclk;
  logic ncs;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire  miso;

  // No pull-up: a released pin reads the inverse of miso_o
  assign miso = miso_oe ? miso_o : ~miso_o;

  modport dev (
    input  sclk,
    input  ncs,
    input  mosi,
    output miso_o,
    output miso_oe
  );

  modport host (
    output sclk,
    output ncs,
    output mosi,
    input  miso
  );
endinterface

// File: design/ssp_dev.sv
`timescale 1ns/1ps
module ssp_dev
  import ssp_pkg::*;
#(
  parameter int RST_CYC      = MOT_RST_CYC,
  parameter int WAKE_CYC     = WAKEUP_CYC,
  parameter int SHDN_CYC     = STDWN_CYC,
  parameter int REST_IN_CYC  = REST_EN_CYC,
  parameter int REST_OUT_CYC = REST_DIS_CYC
) (
  input  wire logic clock,
  input  wire logic reset,
  ssp_if.dev        link,
  output logic      motion_valid,
  output logic      low_power
);

  localparam int CW = 30;

  if (RST_CYC < 1 || WAKE_CYC < 1 || SHDN_CYC < 1 ||
      REST_IN_CYC < 1 || REST_OUT_CYC < 1 ||
      REST_IN_CYC >= (1 << CW) || SHDN_CYC >= (1 << CW))
    $error("ssp_dev: mode delay out of range");

  ////////////////////////////////////////////////////////////////////
  // Link domain (serial clock) state
  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] sh;
    logic [6:0] addr;
    logic       wr;
    logic       burst;
    logic [7:0] rd;
  } sspd_xfer_t;

  typedef struct packed {
    logic              shdn;
    logic [REST_W-1:0] rest;
    logic              srt_tog;
    logic [1:0]        st_s1;
    logic [1:0]        st_s2;
  } sspd_cfg_t;

  sspd_xfer_t x_reg;
  sspd_xfer_t x_next;
  sspd_cfg_t  c_reg;
  sspd_cfg_t  c_next;
  logic       miso_reg;
  logic [7:0] stat_byte;

  assign stat_byte = {6'h00, c_reg.st_s2};

  // Read phase only; deselect drops the driver at once
  assign link.miso_oe = !link.ncs && !x_reg.wr &&
                        (x_reg.cnt >= CNT_DATA0);
  assign link.miso_o  = miso_reg;

  always_comb begin
    logic [7:0] byte_in;
    byte_in = {x_reg.sh, link.mosi};
    x_next = x_reg;
    c_next = c_reg;
    c_next.st_s1 = {low_power, motion_valid};
    c_next.st_s2 = c_reg.st_s1;
    // Port stays idle once a plain transfer is complete
    if (x_reg.cnt != CNT_DONE) begin
      x_next.sh  = byte_in[6:0];
      x_next.cnt = x_reg.cnt + 1'b1;
      if (x_reg.cnt == CNT_ADDR) begin
        x_next.addr = byte_in[6:0];
        x_next.wr   = byte_in[WR_FLAG_BIT];
        x_next.burst = !byte_in[WR_FLAG_BIT] &&
                       (byte_in[6:0] == ADDR_BURST);
        case (byte_in[6:0])
          ADDR_STATUS:   x_next.rd = stat_byte;
          ADDR_BURST:    x_next.rd = stat_byte;
          ADDR_SHUTDOWN: x_next.rd = {7'h00, c_reg.shdn};
          ADDR_REST:     x_next.rd = {6'h00, c_reg.rest};
          default:       x_next.rd = 8'h00;
        endcase
      end
      if (x_reg.cnt == CNT_LAST) begin
        if (x_reg.wr) begin
          case (x_reg.addr)
            ADDR_SHUTDOWN: c_next.shdn = byte_in[SHDN_BIT];
            ADDR_REST:     c_next.rest = byte_in[REST_LSB+:REST_W];
            ADDR_SOFT_RESET: c_next.srt_tog = !c_reg.srt_tog;
            default: ;
          endcase
        end else if (x_reg.burst) begin
          // Burst keeps streaming status until deselect
          x_next.cnt = CNT_DATA0;
          x_next.rd  = stat_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transfer state, cleared whenever select goes high
  always_ff @(posedge link.sclk or posedge link.ncs) begin
    if (link.ncs) begin
      x_reg <= '0;
    end else begin
      x_reg <= x_next;
    end
  end

  // Settings survive deselect; cleared only by system reset
  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      c_reg <= '0;
    end else if (!link.ncs) begin
      c_reg <= c_next;
    end
  end

  // Miso changes only on falling edges or deselect and holds a full period
  always_ff @(negedge link.sclk or posedge link.ncs) begin
    if (link.ncs) begin
      miso_reg <= 1'b0;
    end else if (!x_reg.wr && x_reg.cnt >= CNT_DATA0 &&
                 x_reg.cnt != CNT_DONE) begin
      miso_reg <= x_reg.rd[~x_reg.cnt[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode sequencer on the internal clock
  typedef enum logic [1:0] {
    SSPD_RUN,
    SSPD_WARM,
    SSPD_ENTER_LP,
    SSPD_LOW
  } sspd_mode_t;

  typedef struct packed {
    logic [2:0]    s1;
    logic [2:0]    s2;
    logic          tog_d;
    sspd_mode_t    mode;
    logic [CW-1:0] cnt;
    logic          by_sd;
    logic          mv;
    logic          lp;
  } sspd_sys_t;

  sspd_sys_t s_reg;
  sspd_sys_t s_next;

  assign motion_valid = s_reg.mv;
  assign low_power    = s_reg.lp;

  always_comb begin
    logic sd;
    logic rs;
    sd = s_reg.s2[0];
    rs = s_reg.s2[1];
    s_next = s_reg;
    s_next.s1    = {c_reg.srt_tog, |c_reg.rest, c_reg.shdn};
    s_next.s2    = s_reg.s1;
    s_next.tog_d = s_reg.s2[2];
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    case (s_reg.mode)
      SSPD_RUN, SSPD_WARM: begin
        if (s_reg.mode == SSPD_WARM && s_reg.cnt == '0) begin
          s_next.mode = SSPD_RUN;
        end
        if (sd || rs) begin
          s_next.mode  = SSPD_ENTER_LP;
          s_next.by_sd = sd;
          s_next.cnt   = sd ? CW'(SHDN_CYC) : CW'(REST_IN_CYC);
        end
      end
      SSPD_ENTER_LP: begin
        if (s_reg.by_sd ? !sd : !rs) begin
          s_next.mode = SSPD_WARM;
          s_next.cnt  = s_reg.by_sd ? CW'(WAKE_CYC) : CW'(REST_OUT_CYC);
        end else if (s_reg.cnt == '0) begin
          s_next.mode = SSPD_LOW;
        end
      end
      SSPD_LOW: begin
        if (!sd && !rs) begin
          s_next.mode = SSPD_WARM;
          s_next.cnt  = s_reg.by_sd ? CW'(WAKE_CYC)
                                    : CW'(REST_OUT_CYC);
        end
      end
      default: s_next.mode = SSPD_WARM;
    endcase
    // Soft reset restarts the motion warm-up
    if (s_reg.s2[2] != s_reg.tog_d) begin
      s_next.mode = SSPD_WARM;
      s_next.cnt  = CW'(RST_CYC);
    end
    s_next.mv = (s_next.mode == SSPD_RUN);
    s_next.lp = (s_next.mode == SSPD_LOW);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_reg      <= '0;
      s_reg.mode <= SSPD_WARM;
      s_reg.cnt  <= CW'(RST_CYC);
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // ssp_dev

// File: test/ssp_chk.sv
`timescale 1ns/1ps
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sclk,
  input wire logic ncs,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  typedef struct packed {
    logic [11:0] since;
    logic [4:0]  rises;
    logic [3:0]  hi;
    logic        rd;
    logic        last_wr;
    logic        sclk_q;
  } ssp_chk_t;
  ssp_chk_t st_reg;
  ssp_chk_t st_next;
  logic     rise;

  // Frame bookkeeping; counters saturate so idles never wrap
  always_comb begin
    st_next = st_reg;
    rise = sclk && !st_reg.sclk_q && !ncs;
    st_next.sclk_q = sclk;
    if (rise) st_next.since = 12'h001;
    else if (st_reg.since != 12'hfff) st_next.since = st_reg.since + 12'h1;
    if (ncs) st_next.rises = 5'h00;
    else if (rise && st_reg.rises != 5'h1f)
      st_next.rises = st_reg.rises + 5'h1;
    if (!ncs) st_next.hi = 4'h0;
    else if (st_reg.hi != 4'hf) st_next.hi = st_reg.hi + 4'h1;
    st_next.rd = !ncs && (st_reg.rd || miso_oe);
    // Frame kind latched as select rises, before rd clears
    if (ncs && st_reg.hi == 4'h0) st_next.last_wr = !st_reg.rd;
  end

  // Reset leaves gaps full so the first frame is legal
  always_ff @(posedge clock) begin
    if (reset) st_reg <= '{12'hfff, 5'h00, 4'hf, 1'h0, 1'h0, 1'h1};
    else st_reg <= st_next;
  end

  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  property p_sclk_half;
    $changed(sclk) |=> $stable(sclk) [*6];
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock phase too short");
  property p_miso_hold;
    miso_oe && $past(miso_oe) && sclk && $past(sclk)
      |-> $stable(miso_o) && $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso changed while clock high");
  property p_release;
    $rose(ncs) |-> ##[0:12] !miso_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("miso not released after deselect");
  property p_quiet;
    ncs && $past(ncs) |-> !miso_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("miso driven while deselected");
  property p_mosi_hold;
    !ncs && sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi changed while clock high");
  property p_bexit;
    $fell(ncs) |-> st_reg.hi >= BEXIT_CYC;
  endproperty
  a_bexit: assert property (p_bexit)
    else $error("select high time too short");
  property p_wr_hold;
    $rose(ncs) && !st_reg.rd |-> st_reg.since >= WR_HOLD_CYC;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write select hold too short");
  property p_rd_hold;
    $rose(ncs) && st_reg.rd |-> st_reg.since >= RD_HOLD_CYC;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read select hold too short");
  property p_rad;
    $fell(sclk) && !ncs && miso_oe && st_reg.rises == 5'h08
      |-> st_reg.since >= SRAD_CYC;
  endproperty
  a_rad: assert property (p_rad)
    else $error("address to data gap too short");
  property p_ww;
    $fell(ncs) && st_reg.last_wr |-> st_reg.since >= SWW_CYC;
  endproperty
  a_ww: assert property (p_ww)
    else $error("gap after write too short");
  property p_rw;
    $fell(ncs) && !st_reg.last_wr |-> st_reg.since >= SRW_CYC;
  endproperty
  a_rw: assert property (p_rw)
    else $error("gap after read too short");

  c_write: cover property ($rose(ncs) && !st_reg.rd && st_reg.rises == 5'h10);
  c_read: cover property ($rose(ncs) && st_reg.rd && st_reg.rises == 5'h10);
  c_burst: cover property ($rose(ncs) && st_reg.rises > 5'h10);
endmodule // ssp_chk

// File: test/sensor_serial_port_timing_bench.sv
`timescale 1ns/1ps
module sensor_serial_port_timing_bench;
  import ssp_pkg::*;
  localparam int DCYC = 30;
  typedef struct packed {
    logic       wr;
    logic       bu;
    logic [6:0] ad;
    logic [7:0] wd;
    logic [3:0] ln;
    logic [7:0] ex;
    logic       ok;
  } ssp_row_t;
  logic       clock     = 1'h0;
  logic       dclk      = 1'h0;
  logic       reset     = 1'h1;
  logic       dreset    = 1'h1;
  logic       cmd_valid = 1'h0;
  logic       cmd_write = 1'h0;
  logic       cmd_burst = 1'h0;
  logic [6:0] cmd_addr  = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [3:0] cmd_len   = 4'h0;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       motion_ok;
  logic       motion_valid;
  logic       low_power;
  int         bad_count   = 0;
  int         checks_done = 0;
  int         t;
  int         k;
  ssp_row_t   r;
  // Status byte is {low_power, motion_valid} in bits 1:0
  ssp_row_t   rows [12] = '{
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h01, 1'h0},
    '{1'h1, 1'h0, ADDR_REST, 8'h03, 4'h0, 8'h00, 1'h0},
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h02, 1'h0},
    '{1'h1, 1'h0, ADDR_REST, 8'h00, 4'h0, 8'h00, 1'h0},
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h01, 1'h0},
    '{1'h1, 1'h0, ADDR_SHUTDOWN, 8'h01, 4'h0, 8'h00, 1'h0},
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h02, 1'h0},
    '{1'h1, 1'h0, ADDR_SHUTDOWN, 8'h00, 4'h0, 8'h00, 1'h0},
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h01, 1'h0},
    '{1'h1, 1'h0, ADDR_SOFT_RESET, 8'h00, 4'h0, 8'h00, 1'h1},
    '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h01, 1'h1},
    '{1'h0, 1'h1, ADDR_BURST, 8'h00, 4'h2, 8'h01, 1'h1}};

  // Device oscillator runs apart from the host clock
  always #20 clock = ~clock;
  always #32 dclk = ~dclk;

  ssp_if link_if ();
  ssp_host #(.MOT_WAIT_CYC(60)) ssp_host_inst (
    .clock(clock), .reset(reset), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_burst(cmd_burst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_len(cmd_len), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .motion_ok(motion_ok));
  ssp_dev #(.RST_CYC(DCYC), .WAKE_CYC(DCYC), .SHDN_CYC(DCYC),
    .REST_IN_CYC(DCYC), .REST_OUT_CYC(DCYC)) ssp_dev_inst (
    .clock(dclk), .reset(dreset), .link(link_if),
    .motion_valid(motion_valid), .low_power(low_power));
  ssp_chk ssp_chk_inst (
    .clock(clock), .reset(reset), .sclk(link_if.sclk), .ncs(link_if.ncs),
    .mosi(link_if.mosi), .miso_o(link_if.miso_o),
    .miso_oe(link_if.miso_oe), .miso(link_if.miso));

  ////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return cmd_ready;
      1: return rsp_valid;
      2: return motion_valid;
      default: return low_power;
    endcase
  endfunction

  // Bounded wait; a hang counts as a mismatch and ends the run
  task wait_on(input int s, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge clock);
      if (pick(s) === v) break;
    end
    if (n == lim) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // Request held until the edge that samples ready high
  task send(input ssp_row_t c);
    int n;
    cmd_write <= c.wr;
    cmd_burst <= c.bu;
    cmd_addr  <= c.ad;
    cmd_wdata <= c.wd;
    cmd_len   <= c.ln;
    cmd_valid <= 1'h1;
    wait_on(0, 1'h1, 4000, n);
    cmd_valid <= 1'h0;
  endtask

  task finish(input ssp_row_t c);
    int n;
    repeat (c.wr ? 0 : (c.bu ? c.ln + 1 : 1)) begin
      wait_on(1, 1'h1, 6000, n);
      check(rsp_data, c.ex);
    end
    wait_on(0, 1'h1, 6000, n);
    check(motion_ok, c.ok);
    if (!c.wr) check({low_power, motion_valid}, c.ex[1:0]);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    reset  <= 1'h0;
    dreset <= 1'h0;
    repeat (2) @(posedge clock);
    check({link_if.ncs, link_if.sclk, rsp_valid, motion_ok}, 4'hc);
    check(link_if.miso_oe, 1'h0);
    check(cmd_ready, 1'h1);
    for (k = 0; k < 12; k++) begin
      send(rows[k]);
      finish(rows[k]);
    end
    // Soft reset: motion held off for the restart time
    r = '{1'h1, 1'h0, ADDR_SOFT_RESET, 8'h00, 4'h0, 8'h00, 1'h1};
    send(r);
    wait_on(2, 1'h0, 1000, t);
    check(motion_ok, 1'h0);
    wait_on(2, 1'h1, 3000, t);
    check(t * 40 + 80 >= DCYC * 64, 1);
    check(motion_ok, 1'h0);
    finish(r);
    // Shutdown entry bounded; exit needs the wake time
    r = '{1'h1, 1'h0, ADDR_SHUTDOWN, 8'h01, 4'h0, 8'h00, 1'h0};
    send(r);
    wait_on(3, 1'h1, 3000, t);
    check(t * 40 <= (SCLK_HALF_CYC * 32 + 8) * 40 + (DCYC + 5) * 64, 1);
    finish(r);
    r.wd = 8'h00;
    send(r);
    wait_on(3, 1'h0, 3000, t);
    wait_on(2, 1'h1, 3000, t);
    check(t * 40 + 80 >= DCYC * 64, 1);
    finish(r);
    // Host reset mid-address: select rises, device must recover
    r = '{1'h0, 1'h0, ADDR_STATUS, 8'h00, 4'h0, 8'h01, 1'h0};
    send(r);
    repeat (100) @(posedge clock);
    reset <= 1'h1;
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    check(link_if.ncs, 1'h1);
    check(link_if.miso_oe, 1'h0);
    repeat (SRAD_CYC) @(posedge clock);
    send(r);
    finish(r);
    report_and_stop();
  end
endmodule // sensor_serial_port_timing_bench
